// file: logic/cwd_watchdog.v
/*
  Configuration watchdog with an AXI4-Lite register slave.
  Holds the oscillator frequency, a guarded 16-bit timeout, a disable
  key register, and sticky interrupt status with a mask.
  Assumes a single clock, i_ref_clk, running at the programmed 5..100 MHz frequency and serving as the oscillator
  clock, and a power state input that is synchronous to it.
*/
// The implementer's own choice: the AXI4-Lite slave port.
`include "cwd_defs.vh"
`default_nettype none

// Behaviour
// - Frequency is 7 bits; writes outside 5..100 are ignored and refused.
// - Frequency field resets to 25.
// - Tick is derived from the oscillator using the programmed frequency.
// - Timeout is counted in 1 ms ticks through a 16-bit count.
// - Counter advances only in the active_power_state power state, else holds.
// - Mismatched complement halves are refused; good writes are accepted.
// - Each accepted kick restarts the countdown from the full timeout.
// - Expiry while enabled initiates a reset.
// - Control upper half is read-only live counter value.
// - Control lower half holds timeout, reset value 1000.
// - Writing the key pattern resets and stops; it is the reset content.
// - Writing zero enables; countdown runs until disabled or reset.
module cwd_watchdog
(
  input  wire        i_ref_clk,
  input  wire        i_arst_n,
  input  wire        i_active_power_state,
  input  wire [11:0] i_awaddr,
  input  wire        i_awvalid,
  output reg         o_awready,
  input  wire [31:0] i_wdata,
  input  wire [3:0]  i_wstrb,
  input  wire        i_wvalid,
  output reg         o_wready,
  output reg  [1:0]  o_bresp,
  output reg         o_bvalid,
  input  wire        i_bready,
  input  wire [11:0] i_araddr,
  input  wire        i_arvalid,
  output reg         o_arready,
  output reg  [31:0] o_rdata,
  output reg  [1:0]  o_rresp,
  output reg         o_rvalid,
  input  wire        i_rready,
  output reg         o_wdog_reset,
  output reg         o_irq
);

  // --------------------------------------------------------------------
  // State
  // --------------------------------------------------------------------
  reg  [6:0]  freq_q;
  reg  [15:0] timeout_q;
  reg  [15:0] count_q;
  reg  [31:0] dis_q;
  reg  [2:0]  stat_q;
  reg  [2:0]  mask_q;
  reg  [11:0] awaddr_q;
  reg  [31:0] wdata_q;
  reg  [3:0]  wstrb_q;
  reg         aw_have_q;
  reg         w_have_q;
  reg         freq_reload_q;
  wire        tick_w;
  wire        enabled_w;
  wire        wr_go_w;
  wire [7:0]  wr_idx_w;
  wire [7:0]  rd_idx_w;
  wire        wr_full_w;
  wire        freq_ok_w;
  wire        guard_ok_w;
  wire        kick_w;
  wire        expire_w;
  reg         wr_nack_d;
  reg  [31:0] rdata_d;
  reg  [1:0]  rresp_d;
  reg  [2:0]  stat_set_d;

  assign enabled_w = (dis_q != `CWD_DIS_KEY);
  assign wr_go_w   = aw_have_q && w_have_q && !o_bvalid;
  assign wr_idx_w  = awaddr_q[9:2];
  assign rd_idx_w  = i_araddr[9:2];
  assign wr_full_w = (awaddr_q[11:10] == 2'h0) && (awaddr_q[1:0] == 2'h0);
  assign freq_ok_w = (wdata_q[6:0] >= `CWD_FREQ_MIN) &&
                     (wdata_q[6:0] <= `CWD_FREQ_MAX) &&
                     (wdata_q[31:7] == 25'h0000000);
  assign guard_ok_w = (wdata_q[31:16] == ~wdata_q[15:0]);
  assign kick_w = wr_go_w && !wr_nack_d &&
                  (wr_idx_w == `CWD_IDX_WDOG);
  assign expire_w = enabled_w && tick_w && i_active_power_state &&
                    (count_q == 16'h0001);

  // --------------------------------------------------------------------
  // Tick prescaler
  // --------------------------------------------------------------------
  cwd_tick_gen u_tick
  (
    .i_ref_clk  (i_ref_clk),
    .i_arst_n   (i_arst_n),
    .i_freq_mhz (freq_q),
    .i_reload   (freq_reload_q),
    .o_tick     (tick_w)
  );

  // --------------------------------------------------------------------
  // Write channel capture
  // --------------------------------------------------------------------
  // Address and data are taken in either order and held until the
  // response is accepted, so only one write is ever in flight.
  always @(posedge i_ref_clk or negedge i_arst_n)
  begin
    if (!i_arst_n)
    begin
      aw_have_q <= 1'b0;
      w_have_q  <= 1'b0;
      awaddr_q  <= 12'h000;
      wdata_q   <= 32'h00000000;
      wstrb_q   <= 4'h0;
      o_awready <= 1'b0;
      o_wready  <= 1'b0;
      o_bvalid  <= 1'b0;
      o_bresp   <= `CWD_RESP_OKAY;
    end
    else
    begin
      o_awready <= !aw_have_q && !o_awready && !o_bvalid;
      o_wready  <= !w_have_q && !o_wready && !o_bvalid;
      if (i_awvalid && o_awready)
      begin
        aw_have_q <= 1'b1;
        awaddr_q  <= i_awaddr;
      end
      if (i_wvalid && o_wready)
      begin
        w_have_q <= 1'b1;
        wdata_q  <= i_wdata;
        wstrb_q  <= i_wstrb;
      end
      if (wr_go_w)
      begin
        o_bvalid  <= 1'b1;
        o_bresp   <= wr_nack_d ? `CWD_RESP_SLVERR : `CWD_RESP_OKAY;
        aw_have_q <= 1'b0;
        w_have_q  <= 1'b0;
      end
      else if (o_bvalid && i_bready)
      begin
        o_bvalid <= 1'b0;
      end
    end
  end

  // --------------------------------------------------------------------
  // Write decode and refusal
  // --------------------------------------------------------------------
  // Partial-lane writes are refused; a guarded register cannot be
  // checked from half a word.
  always @*
  begin
    wr_nack_d = 1'b0;
    if (!wr_full_w || (wstrb_q != 4'hF))
    begin
      wr_nack_d = 1'b1;
    end
    else
    begin
      case (wr_idx_w)
        `CWD_IDX_FREQ:     wr_nack_d = !freq_ok_w;
        `CWD_IDX_WDOG:     wr_nack_d = !guard_ok_w;
        `CWD_IDX_DIS:      wr_nack_d = 1'b0;
        `CWD_IDX_IRQ_STAT: wr_nack_d = 1'b0;
        `CWD_IDX_IRQ_MASK: wr_nack_d = 1'b0;
        `CWD_IDX_CTRL:     wr_nack_d = 1'b0;
        default:           wr_nack_d = 1'b1;
      endcase
    end
  end

  // --------------------------------------------------------------------
  // Registers and countdown
  // --------------------------------------------------------------------
  always @(posedge i_ref_clk or negedge i_arst_n)
  begin
    if (!i_arst_n)
    begin
      freq_q        <= `CWD_FREQ_RST;
      timeout_q     <= `CWD_TIMEOUT_RST;
      count_q       <= `CWD_TIMEOUT_RST;
      dis_q         <= `CWD_DIS_KEY;
      mask_q        <= 3'h0;
      freq_reload_q <= 1'b0;
      o_wdog_reset  <= 1'b0;
    end
    else
    begin
      freq_reload_q <= 1'b0;
      o_wdog_reset  <= expire_w;
      if (wr_go_w && !wr_nack_d && wr_idx_w == `CWD_IDX_FREQ)
      begin
        freq_q        <= wdata_q[6:0];
        freq_reload_q <= 1'b1;
      end
      if (wr_go_w && !wr_nack_d && wr_idx_w == `CWD_IDX_DIS)
      begin
        dis_q <= wdata_q;
      end
      if (wr_go_w && !wr_nack_d && wr_idx_w == `CWD_IDX_IRQ_MASK)
      begin
        mask_q <= wdata_q[2:0];
      end
      if (kick_w)
      begin
        timeout_q <= wdata_q[15:0];
        count_q   <= wdata_q[15:0];
      end
      else if (!enabled_w ||
               (wr_go_w && !wr_nack_d && wr_idx_w == `CWD_IDX_DIS &&
                wdata_q == `CWD_DIS_KEY))
      begin
        count_q <= timeout_q;
      end
      else if (expire_w)
      begin
        count_q <= timeout_q;
      end
      else if (tick_w && i_active_power_state && count_q != 16'h0000)
      begin
        count_q <= count_q - 16'h0001;
      end
    end
  end

  // --------------------------------------------------------------------
  // Interrupt status
  // --------------------------------------------------------------------
  // A new event in the clearing cycle survives the clear.
  always @*
  begin
    stat_set_d = 3'h0;
    stat_set_d[`CWD_IRQ_EXPIRE] = expire_w;
    stat_set_d[`CWD_IRQ_NACK]   = wr_go_w && wr_nack_d;
    stat_set_d[`CWD_IRQ_W]      = kick_w;
  end

  always @(posedge i_ref_clk or negedge i_arst_n)
  begin
    if (!i_arst_n)
    begin
      stat_q <= 3'h0;
      o_irq  <= 1'b0;
    end
    else
    begin
      if (wr_go_w && !wr_nack_d && wr_idx_w == `CWD_IDX_IRQ_STAT)
      begin
        stat_q <= (stat_q & ~wdata_q[2:0]) | stat_set_d;
      end
      else
      begin
        stat_q <= stat_q | stat_set_d;
      end
      o_irq <= |(stat_q & mask_q);
    end
  end

  // --------------------------------------------------------------------
  // Read channel
  // --------------------------------------------------------------------
  always @*
  begin
    rdata_d = 32'h00000000;
    rresp_d = `CWD_RESP_OKAY;
    if (i_araddr[11:10] != 2'h0 || i_araddr[1:0] != 2'h0)
    begin
      rresp_d = `CWD_RESP_SLVERR;
    end
    else
    begin
      case (rd_idx_w)
        `CWD_IDX_FREQ:     rdata_d = {25'h0000000, freq_q};
        `CWD_IDX_WDOG:     rdata_d = {count_q, timeout_q};
        `CWD_IDX_DIS:      rdata_d = dis_q;
        `CWD_IDX_IRQ_STAT: rdata_d = {29'h00000000, stat_q};
        `CWD_IDX_IRQ_MASK: rdata_d = {29'h00000000, mask_q};
        `CWD_IDX_CTRL:     rdata_d = {30'h00000000, i_active_power_state,
                                      enabled_w};
        default:           rresp_d = `CWD_RESP_SLVERR;
      endcase
    end
  end

  always @(posedge i_ref_clk or negedge i_arst_n)
  begin
    if (!i_arst_n)
    begin
      o_arready <= 1'b0;
      o_rvalid  <= 1'b0;
      o_rdata   <= 32'h00000000;
      o_rresp   <= `CWD_RESP_OKAY;
    end
    else
    begin
      o_arready <= !o_arready && !o_rvalid;
      if (i_arvalid && o_arready)
      begin
        o_rvalid  <= 1'b1;
        o_rdata   <= rdata_d;
        o_rresp   <= rresp_d;
        o_arready <= 1'b0;
      end
      else if (o_rvalid && i_rready)
      begin
        o_rvalid <= 1'b0;
      end
    end
  end

endmodule // cwd_watchdog

`default_nettype wire

// file: logic/cwd_defs.vh
/*
  Constants for the configuration watchdog: register indices, reset
  values, field positions, bus responses and the tick scale.
  Assumes inclusion by the watchdog modules, the checker and the bench.
*/
`ifndef CWD_DEFS_VH
`define CWD_DEFS_VH

// ----------------------------------------------------------------------
// Register indices (byte address is four times the index)
// ----------------------------------------------------------------------
`define CWD_IDX_FREQ        8'h51
`define CWD_IDX_WDOG        8'hD6
`define CWD_IDX_DIS         8'hD7
`define CWD_IDX_IRQ_STAT    8'hE0
`define CWD_IDX_IRQ_MASK    8'hE1
`define CWD_IDX_CTRL        8'hE2

// ----------------------------------------------------------------------
// Reset values and limits
// ----------------------------------------------------------------------
`define CWD_FREQ_RST        7'h19
`define CWD_FREQ_MIN        7'h05
`define CWD_FREQ_MAX        7'h64
`define CWD_TIMEOUT_RST     16'h03E8
`define CWD_DIS_KEY         32'h0D15AB1E
`define CWD_EN_KEY          32'h00000000
`define CWD_CYC_PER_MHZ_MS  17'h003E8

// ----------------------------------------------------------------------
// Interrupt status bits
// ----------------------------------------------------------------------
`define CWD_IRQ_EXPIRE      0
`define CWD_IRQ_NACK        1
`define CWD_IRQ_W           2

// ----------------------------------------------------------------------
// Bus responses
// ----------------------------------------------------------------------
`define CWD_RESP_OKAY       2'h0
`define CWD_RESP_SLVERR     2'h2

`endif

// file: logic/cwd_tick_gen.v
/*
  Millisecond tick prescaler for the watchdog.
  Assumes i_freq_mhz lies in the valid range and that i_reload pulses
  whenever the frequency value changes.
*/
`include "cwd_defs.vh"
`default_nettype none

module cwd_tick_gen
(
  input  wire        i_ref_clk,
  input  wire        i_arst_n,
  input  wire [6:0]  i_freq_mhz,
  input  wire        i_reload,
  output reg         o_tick
);

  // --------------------------------------------------------------------
  // Prescaler
  // --------------------------------------------------------------------
  wire [16:0] period_w;
  reg  [16:0] cnt_q;

  // One tick every frequency times 1000 oscillator cycles.
  assign period_w = {10'h000, i_freq_mhz} * `CWD_CYC_PER_MHZ_MS;

  always @(posedge i_ref_clk or negedge i_arst_n)
  begin
    if (!i_arst_n)
    begin
      cnt_q  <= 17'h00000;
      o_tick <= 1'b0;
    end
    else if (i_reload)
    begin
      cnt_q  <= 17'h00000;
      o_tick <= 1'b0;
    end
    else if (cnt_q == period_w - 17'h00001)
    begin
      cnt_q  <= 17'h00000;
      o_tick <= 1'b1;
    end
    else
    begin
      cnt_q  <= cnt_q + 17'h00001;
      o_tick <= 1'b0;
    end
  end

endmodule // cwd_tick_gen

`default_nettype wire

// file: dv/cwd_watchdog_asserts.sv
/*
  Checker for cwd_watchdog: bus timing, responses and reset pulse.
  Assumes it is bound into cwd_watchdog and sees only its ports.
*/
`include "cwd_defs.vh"
`default_nettype none

module cwd_watchdog_asserts
(
  input wire logic        i_ref_clk,
  input wire logic        i_arst_n,
  input wire logic [11:0] i_awaddr,
  input wire logic        i_awvalid,
  input wire logic        o_awready,
  input wire logic [31:0] i_wdata,
  input wire logic [3:0]  i_wstrb,
  input wire logic        i_wvalid,
  input wire logic        o_wready,
  input wire logic [1:0]  o_bresp,
  input wire logic        o_bvalid,
  input wire logic        i_bready,
  input wire logic [11:0] i_araddr,
  input wire logic        i_arvalid,
  input wire logic        o_arready,
  input wire logic [31:0] o_rdata,
  input wire logic [1:0]  o_rresp,
  input wire logic        o_rvalid,
  input wire logic        i_rready,
  input wire logic        o_wdog_reset
);
  timeunit 1ns;
  timeprecision 1ps;
  // ------------
  // Captured requests
  // ------------
  // Requests are held past their handshakes, so that a response is
  // judged against the request that caused it.
  logic [11:0] wa_q;
  logic [11:0] ra_q;
  logic [35:0] wd_q;
  wire logic [9:0] ri = ra_q[11:2];
  wire logic       ra_map = ri == `CWD_IDX_FREQ || ri == `CWD_IDX_WDOG ||
    ri == `CWD_IDX_DIS || (ri >= `CWD_IDX_IRQ_STAT && ri <= `CWD_IDX_CTRL);

  always_ff @(posedge i_ref_clk or negedge i_arst_n)
  begin
    if (!i_arst_n)
    begin
      wa_q <= 12'h000;
      ra_q <= 12'h000;
      wd_q <= 36'h0;
    end
    else
    begin
      if (i_awvalid && o_awready)
        wa_q <= i_awaddr;
      if (i_arvalid && o_arready)
        ra_q <= i_araddr;
      if (i_wvalid && o_wready)
        wd_q <= {i_wstrb, i_wdata};
    end
  end

  // ------------
  // Properties
  // ------------
  default clocking cb @(posedge i_ref_clk);
  endclocking
  default disable iff (!i_arst_n);

  AST_B_HOLD: assert property (o_bvalid && !i_bready |=>
    o_bvalid && $stable(o_bresp)) else $error("bresp dropped");
  AST_R_HOLD: assert property (o_rvalid && !i_rready |=>
    o_rvalid && $stable(o_rdata)) else $error("rdata dropped");
  AST_R_NEXT: assert property (i_arvalid && o_arready |=> o_rvalid)
    else $error("read answer late");
  AST_PULSE: assert property (o_wdog_reset |=> !o_wdog_reset)
    else $error("reset pulse too long");
  AST_FREQ_RD: assert property (o_rvalid && ri == `CWD_IDX_FREQ |->
    o_rdata[31:7] == 25'h0 && o_rdata[6:0] >= `CWD_FREQ_MIN &&
    o_rdata[6:0] <= `CWD_FREQ_MAX) else $error("bad frequency read");
  AST_CNT_RD: assert property (o_rvalid && ri == `CWD_IDX_WDOG |->
    o_rdata[31:16] <= o_rdata[15:0]) else $error("count above timeout");
  AST_UNMAP: assert property (o_rvalid && !ra_map |->
    o_rresp == `CWD_RESP_SLVERR && o_rdata == 32'h0)
    else $error("unmapped read answered");
  AST_TO_RESP: assert property (o_bvalid && wa_q == 12'h358 |->
    (o_bresp == `CWD_RESP_SLVERR) == (wd_q[35:32] != 4'hF ||
    wd_q[31:16] != ~wd_q[15:0])) else $error("timeout reply wrong");
  AST_FQ_RESP: assert property (o_bvalid && wa_q == 12'h144 |->
    (o_bresp == `CWD_RESP_SLVERR) == (wd_q[35:32] != 4'hF ||
    wd_q[31:0] < `CWD_FREQ_MIN || wd_q[31:0] > `CWD_FREQ_MAX))
    else $error("frequency reply wrong");

  CV_EXPIRE: cover property (o_wdog_reset);
  CV_NACK: cover property (o_bvalid && o_bresp == `CWD_RESP_SLVERR);
  CV_CNT: cover property (o_rvalid && ri == `CWD_IDX_WDOG);
endmodule // cwd_watchdog_asserts

bind cwd_watchdog cwd_watchdog_asserts u_chk (.*);

`default_nettype wire

// file: dv/tb.sv
/*
  Self-checking bench for cwd_watchdog over AXI4-Lite.
  Assumes the checker binds itself to the design.
*/
`include "cwd_defs.vh"
`default_nettype none

module tb;
  timeunit 1ns;
  timeprecision 1ps;
  // ------------
  // Signals
  // ------------
  logic             i_ref_clk = 1'b0;
  logic             i_arst_n = 1'b0;
  logic             i_active_power_state = 1'b1;
  logic [11:0]      i_awaddr = 12'h000;
  logic             i_awvalid = 1'b0;
  logic [31:0]      i_wdata = 32'h0;
  logic [3:0]       i_wstrb = 4'hF;
  logic             i_wvalid = 1'b0;
  logic             i_bready = 1'b0;
  logic [11:0]      i_araddr = 12'h000;
  logic             i_arvalid = 1'b0;
  logic             i_rready = 1'b0;
  wire logic        o_awready, o_wready, o_bvalid, o_arready, o_rvalid;
  wire logic        o_wdog_reset, o_irq;
  wire logic [1:0]  o_bresp, o_rresp;
  wire logic [31:0] o_rdata;
  logic [31:0]      rv;
  logic [31:0]      fv [6] = '{4, 5, 101, 100, 128, 5};
  logic [31:0]      fe [6] = '{25, 5, 5, 100, 100, 5};
  int               miscompares = 0;
  int               n_tests = 0;
  int               npulse = 0;
  localparam logic [1:0]  OK = `CWD_RESP_OKAY;
  localparam logic [1:0]  NK = `CWD_RESP_SLVERR;
  localparam logic [11:0] AF = 12'h144;
  localparam logic [11:0] AW = 12'h358;
  localparam logic [11:0] AD = 12'h35C;

  cwd_watchdog DUT (.*);

  initial
    forever #2.5 i_ref_clk = ~i_ref_clk;

  always @(posedge i_ref_clk)
    if (o_wdog_reset === 1'b1)
      npulse <= npulse + 1;

  // ------------
  // Tasks
  // ------------
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    n_tests++;
    if (g !== e)
    begin
      miscompares++;
      $display("FAIL %0t got %h expected %h", $time, g, e);
    end
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] d,
                    input logic [1:0] e);
    logic ad;
    logic dd;
    @(posedge i_ref_clk);
    i_awaddr <= a;
    i_wdata <= d;
    i_awvalid <= 1'b1;
    i_wvalid <= 1'b1;
    i_bready <= 1'b1;
    ad = 1'b0;
    dd = 1'b0;
    while (!(ad && dd))
    begin
      @(posedge i_ref_clk);
      if (i_awvalid && o_awready === 1'b1)
      begin
        ad = 1'b1;
        i_awvalid <= 1'b0;
      end
      if (i_wvalid && o_wready === 1'b1)
      begin
        dd = 1'b1;
        i_wvalid <= 1'b0;
      end
    end
    do @(posedge i_ref_clk); while (o_bvalid !== 1'b1);
    chk(o_bresp, e);
    i_bready <= 1'b0;
  endtask

  task automatic rd(input logic [11:0] a, output logic [31:0] d,
                    input logic [1:0] e);
    @(posedge i_ref_clk);
    i_araddr <= a;
    i_arvalid <= 1'b1;
    i_rready <= 1'b1;
    do @(posedge i_ref_clk); while (o_arready !== 1'b1);
    i_arvalid <= 1'b0;
    do @(posedge i_ref_clk); while (o_rvalid !== 1'b1);
    chk(o_rresp, e);
    d = o_rdata;
    i_rready <= 1'b0;
  endtask

  task automatic rdc(input logic [11:0] a, input logic [31:0] e);
    logic [31:0] d;
    rd(a, d, OK);
    chk(d, e);
  endtask

  task automatic test_done;
    $display("tests %0d miscompares %0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  // ------------
  // Sequence
  // ------------
  // The limit leaves room for about 90000 cycles against some 70000.
  initial
  begin
    #450000;
    miscompares++;
    test_done();
  end

  initial
  begin
    repeat (5) @(posedge i_ref_clk);
    i_arst_n <= 1'b1;
    rdc(AF, 32'h19);
    rdc(AW, {2{`CWD_TIMEOUT_RST}});
    rdc(AD, `CWD_DIS_KEY);
    rdc(12'h388, 32'h2);
    rd(12'h000, rv, NK);
    chk(rv, 32'h0);
    wr(12'h000, 32'h1, NK);
    for (int i = 0; i < 6; i++)
    begin
      wr(AF, fv[i], (fv[i] >= 5 && fv[i] <= 100) ? OK : NK);
      rdc(AF, fe[i]);
    end
    wr(AW, 32'hFFFD0003, NK);
    wr(AW, 32'hFFFC0003, OK);
    i_wstrb <= 4'h3;
    wr(AW, 32'hFFFE0001, NK);
    i_wstrb <= 4'hF;
    rdc(AW, 32'h00030003);
    wr(12'h384, 32'h0, OK);
    wr(AD, `CWD_EN_KEY, OK);
    repeat (9500) @(posedge i_ref_clk);
    chk(npulse, 0);
    repeat (6000) @(posedge i_ref_clk);
    chk(npulse, 1);
    chk(o_irq, 1'b0);
    rd(12'h380, rv, OK);
    chk(rv, 32'h7);
    wr(12'h384, 32'h1, OK);
    repeat (2) @(posedge i_ref_clk);
    chk(o_irq, 1'b1);
    wr(12'h380, 32'h1, OK);
    repeat (2) @(posedge i_ref_clk);
    chk(o_irq, 1'b0);
    rdc(12'h380, 32'h6);
    for (int i = 0; i < 3; i++)
    begin
      repeat (7000) @(posedge i_ref_clk);
      wr(AW, 32'hFFFC0003, OK);
    end
    chk(npulse, 1);
    i_active_power_state <= 1'b0;
    rd(AW, rv, OK);
    rdc(12'h388, 32'h1);
    repeat (16000) @(posedge i_ref_clk);
    rdc(AW, rv);
    chk(npulse, 1);
    wr(AD, `CWD_DIS_KEY, OK);
    i_active_power_state <= 1'b1;
    repeat (16000) @(posedge i_ref_clk);
    chk(npulse, 1);
    rdc(AW, 32'h00030003);
    test_done();
  end
endmodule // tb

`default_nettype wire
